// ===== irig_map.vh
`ifndef IRIG_MAP_VH
`define IRIG_MAP_VH
// ==========================================
// Host port offsets
`define PORT_INDEX 8'h16
`define PORT_DATA 8'h17
// ==========================================
// Write register indexes
`define REG_SEC_PRESET 5'h00
`define REG_MIN_PRESET 5'h01
`define REG_HR_PRESET 5'h02
`define REG_DAY_PRESET 5'h03
`define REG_HDAY_PRESET 5'h04
`define REG_CF_A 5'h05
`define REG_CF_B 5'h06
`define REG_CF_C 5'h07
`define REG_CF_D 5'h08
`define REG_MSEC_LOW 5'h09
`define REG_MSEC_HIGH 5'h0a
`define REG_CONTROL 5'h0b
`define REG_HOLD_FRAC 5'h0c
`define REG_HOLD_SEC 5'h0d
// ==========================================
// Read register indexes
`define RD_FRAC 5'h00
`define RD_SEC 5'h01
`define RD_MIN 5'h02
`define RD_HR 5'h03
`define RD_DAY 5'h04
`define RD_HDAY 5'h05
// ==========================================
// Control register fields
`define CTL_MSB_BIT 0
`define CTL_FREEZE_BIT 1
`define CTL_MODE_HI 3
`define CTL_MODE_LO 2
`define CTL_RATE_HI 5
`define CTL_RATE_LO 4
`define CTL_LOAD_BIT 7
`define HOLD_FLAG_BIT 7
`define RESET_BYTE 8'h00
// ==========================================
// Timing
`define CLOCK_HZ 10000000
`define HUNDREDTH_HZ 100
`define CYCLES_PER_HUNDREDTH (`CLOCK_HZ / `HUNDREDTH_HZ)
`endif

// ===== bcd_digit.v
`timescale 1ns/1ps
// ==========================================
// One BCD digit with preset and rollover
module bcd_digit #(
	parameter LIMIT = 4'h9
) (
	// Clock and reset
	input wire clock,
	input wire resetn,
	// Control
	input wire load,
	input wire [3:0] load_value,
	input wire step,
	input wire force_wrap,
	// Digit
	output reg [3:0] digit_q,
	output wire carry
);
	assign carry = step & ((digit_q == LIMIT) | force_wrap);
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			digit_q <= 4'h0;
		end else if (load) begin
			digit_q <= load_value;
		end else if (carry) begin
			digit_q <= 4'h0;
		end else if (step) begin
			digit_q <= digit_q + 4'h1;
		end
	end
endmodule // bcd_digit

// ===== irig_time_code_generator.v
`timescale 1ns/1ps
`include "irig_map.vh"
// Summary of operation
// - Host writes index at 0x16, then reads or writes the register at 0x17.
// - BCD presets for seconds, minutes, hours, days, hundreds of days held.
// - Control-function bits stored in write registers 05 to 08.
// - 17-bit seconds-from-midnight preset from 09, 0A and control bit 0.
// - Freeze bit stops the seconds count.
// - Control bits 3..2 select IRIG B, A or G.
// - Control bits 5..4 select real, half or double rate.
// - Control write with load bit restarts frame, clears fraction, loads presets.
// - Running BCD time readable in read registers 00 to 05.
// - Hold target in 0C and 0D, ignored unless hold flag set.
// - Hold flag blocks fresh simulator data; data clock keeps running.
// - On target match, data released and hold flag cleared together.
// - Hold flag reported in bit 7 of seconds read register.
module irig_time_code_generator #(
	parameter TICK_CYCLES = `CYCLES_PER_HUNDREDTH
) (
	// Clock and reset
	input wire clock,
	input wire resetn,
	// Host port
	input wire [7:0] host_addr,
	input wire [7:0] host_wdata,
	input wire host_wr,
	input wire host_rd,
	output reg [7:0] host_rdata_q,
	// Simulator coupling
	input wire sim_run,
	output reg data_enable_q,
	output reg data_clock_enable_q,
	// Generator state
	output reg [1:0] format_q,
	output reg [1:0] rate_q,
	output reg frame_start_q,
	output reg [16:0] midnight_seconds_q,
	output reg [35:0] control_functions_q
);

	// ==========================================
	// Decode helpers
	// Port decode is shared by the index write, data write and data read
	function port_hit;
		input [7:0] addr;
		input [7:0] port;
		begin
			port_hit = (addr == port);
		end
	endfunction

	// Tick length per hundredth; the reserved rate code runs at real time
	function [31:0] rate_limit;
		input [1:0] rate;
		input [31:0] base;
		begin
			case (rate)
			2'b01: rate_limit = base * 2;
			2'b10: rate_limit = base / 2;
			default: rate_limit = base;
			endcase
		end
	endfunction

	// True when a tens and units digit pair shows the given value
	function pair_is;
		input [3:0] tens;
		input [3:0] units;
		input [7:0] value;
		begin
			pair_is = ({tens, units} == value);
		end
	endfunction

	// Seconds within the minute and hundredths against the hold target
	function hold_match;
		input [15:0] now;
		input [7:0] sec_target;
		input [7:0] frac_target;
		begin
			hold_match = (now[15:8] == {1'b0, sec_target[6:0]}) & (now[7:0] == frac_target);
		end
	endfunction

	// Readback byte for one read index; unlisted indexes read as zero
	function [7:0] read_byte;
		input [4:0] idx;
		input [43:0] now;
		input flag;
		begin
			case (idx)
			`RD_FRAC: read_byte = now[7:0];
			`RD_SEC: read_byte = {flag, now[14:8]};
			`RD_MIN: read_byte = {1'b0, now[22:16]};
			`RD_HR: read_byte = {2'b00, now[29:24]};
			`RD_DAY: read_byte = now[39:32];
			`RD_HDAY: read_byte = {4'h0, now[43:40]};
			default: read_byte = 8'h00;
			endcase
		end
	endfunction

	// ==========================================
	// Host registers
	reg [4:0] index_q;

	reg [7:0] sec_pre_q;
	reg [7:0] min_pre_q;
	reg [7:0] hr_pre_q;
	reg [7:0] day_pre_q;
	reg [7:0] hday_pre_q;
	reg [7:0] msec_lo_q;
	reg [7:0] msec_hi_q;
	reg [7:0] control_q;
	reg [7:0] hold_frac_q;
	reg [7:0] hold_sec_q;

	wire index_wr = host_wr & port_hit(host_addr, `PORT_INDEX);
	wire data_wr = host_wr & port_hit(host_addr, `PORT_DATA);
	wire data_rd = host_rd & port_hit(host_addr, `PORT_DATA);
	wire load = data_wr & (index_q == `REG_CONTROL) & host_wdata[`CTL_LOAD_BIT];
	reg hold_clear;

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			index_q <= 5'h00;
			sec_pre_q <= `RESET_BYTE;
			min_pre_q <= `RESET_BYTE;
			hr_pre_q <= `RESET_BYTE;
			day_pre_q <= `RESET_BYTE;
			hday_pre_q <= `RESET_BYTE;
			control_functions_q <= 36'h0;
			msec_lo_q <= `RESET_BYTE;
			msec_hi_q <= `RESET_BYTE;
			control_q <= `RESET_BYTE;
			hold_frac_q <= `RESET_BYTE;
			hold_sec_q <= `RESET_BYTE;
		end else begin
			if (index_wr) begin
				index_q <= host_wdata[4:0];
			end
			if (hold_clear) begin
				hold_sec_q[`HOLD_FLAG_BIT] <= 1'b0;
			end
			if (data_wr) begin
				// After the match clear, so a host write of the target wins
				case (index_q)
				`REG_SEC_PRESET: begin
					sec_pre_q <= {1'b0, host_wdata[6:0]};
				end
				`REG_MIN_PRESET: begin
					min_pre_q <= {1'b0, host_wdata[6:0]};
				end
				`REG_HR_PRESET: begin
					hr_pre_q <= {2'b00, host_wdata[5:0]};
				end
				`REG_DAY_PRESET: begin
					day_pre_q <= host_wdata;
				end
				`REG_HDAY_PRESET: begin
					hday_pre_q <= {6'h00, host_wdata[1:0]};
				end
				`REG_CF_A: begin
					control_functions_q[7:0] <= host_wdata;
				end
				`REG_CF_B: begin
					control_functions_q[15:8] <= host_wdata;
				end
				`REG_CF_C: begin
					control_functions_q[23:16] <= host_wdata;
				end
				`REG_CF_D: begin
					control_functions_q[26:24] <= host_wdata[2:0];
				end
				`REG_MSEC_LOW: begin
					msec_lo_q <= host_wdata;
				end
				`REG_MSEC_HIGH: begin
					msec_hi_q <= host_wdata;
				end
				`REG_CONTROL: begin
					control_q <= host_wdata;
				end
				`REG_HOLD_FRAC: begin
					hold_frac_q <= host_wdata;
				end
				`REG_HOLD_SEC: begin
					hold_sec_q <= host_wdata;
				end
				default: begin
					index_q <= index_q;
				end
				endcase
			end
		end
	end

	// ==========================================
	// Format and rate
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			format_q <= 2'b00;
			rate_q <= 2'b00;
			frame_start_q <= 1'b0;
		end else begin
			// Bit 3 clear always means IRIG B
			format_q <= control_q[`CTL_MODE_HI] ? control_q[3:2] : 2'b00;
			rate_q <= control_q[`CTL_RATE_HI:`CTL_RATE_LO];
			frame_start_q <= load;
		end
	end

	// ==========================================
	// Hundredths tick, scaled by rate
	reg [31:0] tick_count_q;
	reg tick;
	reg [31:0] tick_limit;
	always @* begin
		tick_limit = rate_limit(rate_q, TICK_CYCLES);
		tick = (tick_count_q >= tick_limit - 32'h1);
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tick_count_q <= 32'h0;
		end else if (load | tick) begin
			tick_count_q <= 32'h0;
		end else begin
			tick_count_q <= tick_count_q + 32'h1;
		end
	end

	// ==========================================
	// BCD time chain
	// Digits: hundredths, tenths, s1, s10, m1, m10, h1, h10, d1, d10, d100
	wire [3:0] dig [0:10];
	wire [10:0] carry;
	wire [43:0] time_now;
	// Preset digits; a load always starts at a whole second
	wire [3:0] pre_hundredths = 4'h0;
	wire [3:0] pre_tenths = 4'h0;
	wire [3:0] pre_s1 = sec_pre_q[3:0];
	wire [3:0] pre_s10 = {1'b0, sec_pre_q[6:4]};
	wire [3:0] pre_m1 = min_pre_q[3:0];
	wire [3:0] pre_m10 = {1'b0, min_pre_q[6:4]};
	wire [3:0] pre_h1 = hr_pre_q[3:0];
	wire [3:0] pre_h10 = {2'b00, hr_pre_q[5:4]};
	wire [3:0] pre_d1 = day_pre_q[3:0];
	wire [3:0] pre_d10 = day_pre_q[7:4];
	wire [3:0] pre_d100 = {2'b00, hday_pre_q[1:0]};
	wire [43:0] preset = {pre_d100, pre_d10, pre_d1, pre_h10, pre_h1, pre_m10, pre_m1,
		pre_s10, pre_s1, pre_tenths, pre_hundredths};

	wire freeze = control_q[`CTL_FREEZE_BIT];
	wire day_end = pair_is(dig[7], dig[6], 8'h23);
	wire year_end = pair_is(dig[10], dig[9], 8'h36) & (dig[8] == 4'h5);
	wire sec_step = carry[1] & ~freeze;
	// Roll-over limit of each digit, hundredths in the low nibble
	localparam [43:0] LIMITS = 44'h3_9_9_2_9_5_9_5_9_9_9;

	genvar gi;
	generate
		for (gi = 0; gi < 11; gi = gi + 1) begin : g_digit
			wire step_in;
			wire wrap_in;
			assign time_now[gi*4 +: 4] = dig[gi];
			if (gi == 0) begin : g_first
				assign step_in = tick;
			end else if (gi == 2) begin : g_sec
				assign step_in = sec_step;
			end else begin : g_rest
				assign step_in = carry[gi-1];
			end
			if (gi == 6) begin : g_h1
				assign wrap_in = day_end;
			end else if (gi == 7) begin : g_h10
				assign wrap_in = day_end;
			end else if (gi >= 8) begin : g_day
				assign wrap_in = year_end;
			end else begin : g_none
				assign wrap_in = 1'b0;
			end
			bcd_digit #(.LIMIT(LIMITS[gi*4 +: 4])) u_digit (
				.clock(clock),
				.resetn(resetn),
				.load(load),
				.load_value(preset[gi*4 +: 4]),
				.step(step_in),
				.force_wrap(wrap_in),
				.digit_q(dig[gi]),
				.carry(carry[gi])
			);
		end
	endgenerate

	// ==========================================
	// Binary seconds from midnight
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			midnight_seconds_q <= 17'h0;
		end else if (load) begin
			// Uses the msb bit carried in this same control write
			midnight_seconds_q <= {host_wdata[`CTL_MSB_BIT], msec_hi_q, msec_lo_q};
		end else if (sec_step) begin
			midnight_seconds_q <= carry[7] ? 17'h0 : midnight_seconds_q + 17'h1;
		end
	end

	// ==========================================
	// Data hold
	wire hold_flag = hold_sec_q[`HOLD_FLAG_BIT];
	always @* begin
		// Match on seconds within the minute and hundredths
		hold_clear = hold_flag & hold_match(time_now[15:0], hold_sec_q, hold_frac_q);
	end
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			data_enable_q <= 1'b0;
			data_clock_enable_q <= 1'b0;
		end else begin
			data_enable_q <= sim_run & ~(hold_flag & ~hold_clear);
			data_clock_enable_q <= sim_run;
		end
	end

	// ==========================================
	// Readback
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			host_rdata_q <= 8'h00;
		end else if (data_rd) begin
			host_rdata_q <= read_byte(index_q, time_now, hold_flag);
		end else begin
			host_rdata_q <= 8'h00;
		end
	end

endmodule // irig_time_code_generator

// ===== irig_chk_chk.sv
`timescale 1ns/1ps
// ==========================================
// Port checker
module irig_chk (
	// Clock and reset
	input wire clock,
	input wire resetn,
	// Watched ports
	input wire [7:0] host_addr,
	input wire [7:0] host_wdata,
	input wire host_wr,
	input wire host_rd,
	input wire [7:0] host_rdata_q,
	input wire sim_run,
	input wire data_enable_q,
	input wire data_clock_enable_q,
	input wire [1:0] format_q,
	input wire [1:0] rate_q,
	input wire frame_start_q,
	input wire [16:0] midnight_seconds_q
);
	reg [7:0] idx_q, lo_q, hi_q, ctl_q;
	reg ctl_wr_q;
	wire data_wr = host_wr && host_addr == 8'h17;
	// Shadow copy, since the indexed registers cannot be read back
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			{idx_q, lo_q, hi_q, ctl_q, ctl_wr_q} <= 33'h0;
		end else begin
			ctl_wr_q <= data_wr && idx_q == 8'h0b;
			if (host_wr && host_addr == 8'h16) idx_q <= host_wdata;
			if (data_wr && idx_q == 8'h09) lo_q <= host_wdata;
			if (data_wr && idx_q == 8'h0a) hi_q <= host_wdata;
			if (data_wr && idx_q == 8'h0b) ctl_q <= host_wdata;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence load_wr;
		data_wr && idx_q == 8'h0b && host_wdata[7];
	endsequence
	sequence start_pulse;
		frame_start_q ##1 !frame_start_q;
	endsequence
	chk_load_pulse: assert property (load_wr |=> start_pulse)
		else $error("frame start pulse missing");
	chk_load_time: assert property (ctl_wr_q && ctl_q[7] |->
		midnight_seconds_q == {ctl_q[0], hi_q, lo_q}) else $error("preset seconds not loaded");
	chk_freeze_seconds: assert property (ctl_q[1] && !ctl_wr_q |->
		$stable(midnight_seconds_q)) else $error("seconds moved while frozen");
	chk_format_sel: assert property (ctl_wr_q |=>
		format_q == (ctl_q[3] ? ctl_q[3:2] : 2'b00)) else $error("wrong format");
	chk_rate_sel: assert property (ctl_wr_q |=> rate_q == ctl_q[5:4])
		else $error("wrong rate");
	chk_read_idle: assert property (!$past(host_rd && host_addr == 8'h17) |->
		host_rdata_q == 8'h00) else $error("read data outside a read");
	chk_clock_follow: assert property (sim_run |=> data_clock_enable_q)
		else $error("data clock stopped while running");
	chk_data_gate: assert property (data_enable_q |-> data_clock_enable_q)
		else $error("data without run");
	chk_hold_block: assert property (data_wr && idx_q == 8'h0d && host_wdata[7] |->
		##2 !data_enable_q) else $error("data not held");
endmodule // irig_chk
bind irig_time_code_generator irig_chk u_chk (.clock, .resetn, .host_addr, .host_wdata,
	.host_wr, .host_rd, .host_rdata_q, .sim_run, .data_enable_q, .data_clock_enable_q,
	.format_q, .rate_q, .frame_start_q, .midnight_seconds_q);

// ===== irig_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host software model
module irig_host_model (
	// Clock
	input wire clock,
	// Host port
	output reg [7:0] host_addr = 8'h00,
	output reg [7:0] host_wdata = 8'h00,
	output reg host_wr = 1'b0,
	output reg host_rd = 1'b0,
	input wire [7:0] host_rdata_q
);
	// Index first, then the data port
	task put_index(input [7:0] idx);
		begin
			@(posedge clock);
			host_wr <= 1'b1;
			host_addr <= 8'h16;
			host_wdata <= idx;
			@(posedge clock);
		end
	endtask
	task wr(input [7:0] idx, input [7:0] v);
		begin
			put_index(idx);
			host_addr <= 8'h17;
			host_wdata <= v;
			@(posedge clock);
			host_wr <= 1'b0;
			host_wdata <= ~v;
		end
	endtask
	task rd(input [7:0] idx, output [7:0] v);
		begin
			put_index(idx);
			host_wr <= 1'b0;
			host_rd <= 1'b1;
			host_addr <= 8'h17;
			host_wdata <= ~idx;
			@(posedge clock);
			host_rd <= 1'b0;
			#1 v = host_rdata_q;
		end
	endtask
	// Live readback: reread until two passes agree, at most three rereads
	task rd_stable(input [7:0] idx, output [7:0] v);
		reg [7:0] a;
		begin
			rd(idx, v);
			a = ~v;
			repeat (3) if (a !== v) begin
				a = v;
				rd(idx, v);
			end
		end
	endtask
endmodule // irig_host_model

// ===== irig_time_code_generator_tb.sv
`timescale 1ns/1ps
// ==========================================
// Testbench
module irig_time_code_generator_tb;
	reg clock = 1'b0;
	reg resetn = 1'b0;
	reg sim_run = 1'b0;
	wire [7:0] host_addr, host_wdata, host_rdata_q;
	wire host_wr, host_rd, data_enable_q, data_clock_enable_q, frame_start_q;
	wire [1:0] format_q, rate_q;
	wire [16:0] midnight_seconds_q;
	reg [7:0] v;
	integer mismatches = 0;
	integer check_count = 0;
	integer i;
	always #50 clock = ~clock;
	// Short tick: one second is a thousand cycles at real rate
	irig_time_code_generator #(.TICK_CYCLES(10)) u_dut (.clock, .resetn, .host_addr,
		.host_wdata, .host_wr, .host_rd, .host_rdata_q, .sim_run, .data_enable_q,
		.data_clock_enable_q, .format_q, .rate_q, .frame_start_q, .midnight_seconds_q,
		.control_functions_q());
	irig_host_model u_host (.clock, .host_addr, .host_wdata, .host_wr, .host_rd,
		.host_rdata_q);
	task check(input string name, input [16:0] seen, input [16:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("unexpected %s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	task rd_check(input [7:0] idx, input [7:0] exp);
		begin
			u_host.rd_stable(idx, v);
			check($sformatf("reg %h", idx), {9'h0, v}, {9'h0, exp});
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", check_count, mismatches);
			if (mismatches == 0 && check_count > 0) $display("STATUS OK");
			else $display("STATUS NOT OK");
			$finish;
		end
	endtask
	// ==========================================
	// Tests
	initial begin
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		for (i = 0; i < 12; i = i + 1) u_host.wr(8'h0b, {2'b00, i[3:0], 2'b00});
		@(posedge clock);
		#1 check("format", {15'h0, format_q}, 17'h3);
		check("rate", {15'h0, rate_q}, 17'h2);
		$display("test modes done");
		u_host.wr(8'h0b, 8'h20);
		u_host.wr(8'h00, 8'h59);
		u_host.wr(8'h01, 8'h59);
		u_host.wr(8'h02, 8'h23);
		u_host.wr(8'h09, 8'h7f);
		u_host.wr(8'h0a, 8'h51);
		u_host.wr(8'h0b, 8'ha1);
		#1 check("midnight", midnight_seconds_q, 17'h1517f);
		rd_check(8'h01, 8'h59);
		rd_check(8'h03, 8'h23);
		rd_check(8'h0e, 8'h00);
		repeat (600) @(posedge clock);
		rd_check(8'h01, 8'h00);
		rd_check(8'h02, 8'h00);
		rd_check(8'h03, 8'h00);
		check("midnight", midnight_seconds_q, 17'h0);
		$display("test rollover done");
		u_host.wr(8'h0b, 8'h22);
		repeat (600) @(posedge clock);
		check("frozen", midnight_seconds_q, 17'h0);
		$display("test freeze done");
		u_host.wr(8'h0b, 8'h10);
		u_host.wr(8'h00, 8'h00);
		u_host.wr(8'h0b, 8'h90);
		u_host.wr(8'h0c, 8'h00);
		u_host.wr(8'h0d, 8'h81);
		@(posedge clock);
		sim_run <= 1'b1;
		rd_check(8'h01, 8'h80);
		repeat (1200) @(posedge clock);
		check("held", {15'h0, data_enable_q, data_clock_enable_q}, 17'h1);
		i = 0;
		while (data_enable_q !== 1'b1 && i < 1500) begin
			@(posedge clock);
			i = i + 1;
		end
		check("released", {16'h0, data_enable_q}, 17'h1);
		if (i == 1500) tally_and_finish;
		rd_check(8'h01, 8'h01);
		$display("test hold done");
		tally_and_finish;
	end
endmodule // irig_time_code_generator_tb
